// ==== src/gated_frequency_counter.sv ====
// What this block does
// - Count input edges while gate high; a gate fall can add one.
// - Gate source 00 uses gate pin.
// - Interrupt on gate fall, or both edges.
// - Uncleared count holds, resumes next window.
// - Status bit shows current gate state.
// - Counter wrap to zero sets overflow flag.
// - Overflow flag sticks until counter clear.
// - Pin disable bit gates aux output routing.
// - Pin disable affects routing only.
// - High period is (16-code) prescaled ticks.
// - Low period is (16-code) prescaled ticks.
// - Internal gate repeats high then low.
// - High and low codes are separate fields.
// - First internal period may lag one tick.
// - New low code applies from next low.
// - Both-edge mode adds one per gate fall.
// - Falling mode counts falls of input AND gate.
// - Codes 01 internal, 10 aux, 11 reserved.
// - Gate flag one only while run and gate high.
// - Irq edge bit one selects both edges.
`timescale 1ns/1ps
`default_nettype none

module gated_frequency_counter #(
	parameter int COUNT_W = 18
) (
	// Clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Wishbone classic slave
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	// Measured pulse, gate and clock sources
	input  wire logic        measured_pulse_input_i,
	input  wire logic        gate_input_pin_i,
	input  wire logic        aux_timer_output_i,
	input  wire logic        slow_clock_i,
	// Shared port pin and events
	output logic             shared_port_pin_o,
	output logic             shared_port_pin_oe_n_o,
	output logic             measure_interrupt_o,
	output logic             gate_active_o
);

	// Counter must fit the 32-bit read path
	if (COUNT_W < 2 || COUNT_W > 32) begin : g_bad_count_w
		$error("COUNT_W out of range");
	end

	// Registers
	logic [freq_meter_pkg::CTRL_W-1:0]   ctrl_r;
	logic [freq_meter_pkg::PERIOD_W-1:0] period_r;
	logic [COUNT_W-1:0]                  count_r;
	logic                                overflow_r;
	logic                                clear_req;

	// Synchronisers and edge history
	freq_meter_pkg::sync_in_t            meta_r;
	freq_meter_pkg::sync_in_t            sync_r;
	logic                                pulse_prev_r;
	logic                                gate_r;
	logic                                and_prev_r;
	logic                                irq_r;
	logic                                pin_r;
	logic                                pin_oe_n_r;
	logic                                ack_r;
	logic [31:0]                         dat_r;

	// Decoded controls
	logic                                run;
	logic                                ext_src;
	freq_meter_pkg::gate_src_t           gate_src;
	logic                                irq_both;
	logic                                cnt_both;
	logic                                pin_dis;
	freq_meter_pkg::gen_cfg_t            gen_cfg;
	logic                                gen_gate;
	logic                                gate_sel;
	logic                                gate_now;
	logic                                gate_rise;
	logic                                gate_fall;
	logic                                and_now;
	logic                                pulse_edge;
	logic                                inc;
	logic                                bus_req;
	logic                                wr_en;

	assign run      = ctrl_r[freq_meter_pkg::CTRL_RUN_BIT];
	assign ext_src  = ctrl_r[freq_meter_pkg::CTRL_EXTSRC_BIT];
	assign gate_src = freq_meter_pkg::gate_src_t'(ctrl_r[freq_meter_pkg::CTRL_GSRC_LSB +: 2]);
	assign irq_both = ctrl_r[freq_meter_pkg::CTRL_IRQEDGE_BIT];
	assign cnt_both = ctrl_r[freq_meter_pkg::CTRL_CNTEDGE_BIT];
	assign pin_dis  = ctrl_r[freq_meter_pkg::CTRL_PINDIS_BIT];

	assign bus_req  = cyc_i & stb_i & ~ack_r;
	assign wr_en    = bus_req & we_i;
	assign clear_req = wr_en & sel_i[0] & (adr_i == freq_meter_pkg::CLEAR_OFS)
	                 & dat_i[freq_meter_pkg::CLEAR_BIT];

	// Register writes, byte-lane gated
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_r   <= freq_meter_pkg::CTRL_RESET;
			period_r <= freq_meter_pkg::PERIOD_RESET;
		end else if (wr_en) begin
			case (adr_i)
				freq_meter_pkg::CTRL_OFS: begin
					if (sel_i[0]) begin
						ctrl_r[7:0] <= dat_i[7:0];
					end
					if (sel_i[1]) begin
						ctrl_r[freq_meter_pkg::CTRL_W-1:8] <= dat_i[freq_meter_pkg::CTRL_W-1:8];
					end
				end
				freq_meter_pkg::PERIOD_OFS: begin
					if (sel_i[0]) begin
						period_r <= dat_i[freq_meter_pkg::PERIOD_W-1:0];
					end
				end
				default: begin
				end
			endcase
		end
	end

	// Bus answer one cycle after the request, zero on unmapped reads
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
			dat_r <= '0;
		end else begin
			ack_r <= bus_req;
			if (bus_req && !we_i) begin
				case (adr_i)
					freq_meter_pkg::CTRL_OFS:   dat_r <= 32'(ctrl_r);
					freq_meter_pkg::PERIOD_OFS: dat_r <= 32'(period_r);
					freq_meter_pkg::COUNT_OFS:  dat_r <= 32'(count_r);
					freq_meter_pkg::STATUS_OFS: begin
						dat_r <= '0;
						dat_r[freq_meter_pkg::STAT_GATE_BIT] <= gate_r;
						dat_r[freq_meter_pkg::STAT_OVF_BIT]  <= overflow_r;
					end
					default:                    dat_r <= '0;
				endcase
			end else begin
				dat_r <= '0;
			end
		end
	end

	// Two-flop synchronisers for all pin inputs
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= '{pulse: measured_pulse_input_i, gate_pin: gate_input_pin_i,
			            aux: aux_timer_output_i, slow: slow_clock_i};
			sync_r <= meta_r;
		end
	end

	assign gen_cfg = '{enable:    run && gate_src == freq_meter_pkg::GSRC_INTERNAL,
	                   use_slow:  ctrl_r[freq_meter_pkg::CTRL_SLOW_BIT],
	                   clk_sel:   ctrl_r[freq_meter_pkg::CTRL_GCLK_LSB +: 2],
	                   high_code: period_r[freq_meter_pkg::PERIOD_HIGH_LSB +: 4],
	                   low_code:  period_r[freq_meter_pkg::PERIOD_LOW_LSB +: 4]};

	window_gate_gen u_gate_gen (
		.clk_i      (clk_i),
		.rst_i      (rst_i),
		.cfg_i      (gen_cfg),
		.slow_lvl_i (sync_r.slow),
		.gate_o     (gen_gate)
	);

	// Gate source mux; reserved code keeps the gate low
	always_comb begin
		case (gate_src)
			freq_meter_pkg::GSRC_PIN:      gate_sel = sync_r.gate_pin;
			freq_meter_pkg::GSRC_INTERNAL: gate_sel = gen_gate;
			freq_meter_pkg::GSRC_AUX:      gate_sel = sync_r.aux;
			default:                       gate_sel = 1'b0;
		endcase
	end

	assign gate_now   = run & gate_sel;
	assign gate_rise  = gate_now & ~gate_r;
	assign gate_fall  = ~gate_now & gate_r;
	assign and_now    = sync_r.pulse & gate_now;
	assign pulse_edge = sync_r.pulse ^ pulse_prev_r;

	// Count events for either edge mode
	always_comb begin
		if (!ext_src) begin
			inc = 1'b0;
		end else if (cnt_both) begin
			inc = (gate_now & pulse_edge) | gate_fall;
		end else begin
			inc = and_prev_r & ~and_now;
		end
	end

	// Edge history and gate flag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pulse_prev_r <= 1'b0;
			gate_r       <= 1'b0;
			and_prev_r   <= 1'b0;
		end else begin
			pulse_prev_r <= sync_r.pulse;
			gate_r       <= gate_now;
			and_prev_r   <= and_now;
		end
	end

	// Up-counter: holds while gate low unless cleared
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			count_r <= '0;
		end else if (clear_req) begin
			count_r <= COUNT_W'(inc);
		end else if (inc) begin
			count_r <= count_r + 1'b1;
		end
	end

	// Overflow: sticky, cleared only with the counter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			overflow_r <= 1'b0;
		end else if (inc && &count_r && !clear_req) begin
			overflow_r <= 1'b1;
		end else if (clear_req) begin
			overflow_r <= 1'b0;
		end
	end

	// Interrupt pulse on selected gate edges
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= gate_fall | (irq_both & gate_rise);
		end
	end

	// Aux output routing to shared pin; aux timer itself untouched
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pin_r      <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end else begin
			pin_r      <= pin_dis ? 1'b0 : aux_timer_output_i;
			pin_oe_n_r <= pin_dis;
		end
	end

	assign dat_o                  = dat_r;
	assign ack_o                  = ack_r;
	assign shared_port_pin_o      = pin_r;
	assign shared_port_pin_oe_n_o = pin_oe_n_r;
	assign measure_interrupt_o    = irq_r;
	assign gate_active_o          = gate_r;

endmodule : gated_frequency_counter

`default_nettype wire

// ==== src/freq_meter_pkg.sv ====
package freq_meter_pkg;

	// Register byte offsets
	localparam logic [7:0] CTRL_OFS   = 8'h00;
	localparam logic [7:0] CLEAR_OFS  = 8'h04;
	localparam logic [7:0] PERIOD_OFS = 8'h08;
	localparam logic [7:0] COUNT_OFS  = 8'h0C;
	localparam logic [7:0] STATUS_OFS = 8'h10;

	// Control register field positions
	localparam int CTRL_RUN_BIT      = 0;
	localparam int CTRL_EXTSRC_BIT   = 1;
	localparam int CTRL_GSRC_LSB     = 2;
	localparam int CTRL_IRQEDGE_BIT  = 4;
	localparam int CTRL_CNTEDGE_BIT  = 5;
	localparam int CTRL_GCLK_LSB     = 6;
	localparam int CTRL_SLOW_BIT     = 8;
	localparam int CTRL_PINDIS_BIT   = 9;
	localparam int CTRL_W            = 10;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 10'h000;

	// Period register fields
	localparam int PERIOD_HIGH_LSB = 0;
	localparam int PERIOD_LOW_LSB  = 4;
	localparam int PERIOD_W        = 8;
	localparam logic [PERIOD_W-1:0] PERIOD_RESET = 8'h00;

	// Clear register and status bits
	localparam int CLEAR_BIT      = 0;
	localparam int STAT_GATE_BIT  = 0;
	localparam int STAT_OVF_BIT   = 1;

	// Gate period arithmetic
	localparam logic [4:0] PERIOD_BASE = 5'h10;
	localparam int         FAST_SHIFT0 = 12;
	localparam int         SLOW_SHIFT0 = 4;
	localparam int         DIV_W       = 14;

	// Gate source encodings
	typedef enum logic [1:0] {
		GSRC_PIN      = 2'h0,
		GSRC_INTERNAL = 2'h1,
		GSRC_AUX      = 2'h2,
		GSRC_RSVD     = 2'h3
	} gate_src_t;

	// Gate generator states, Gray along idle-wait-high-low
	typedef enum logic [1:0] {
		GEN_IDLE = 2'b00,
		GEN_WAIT = 2'b01,
		GEN_HIGH = 2'b11,
		GEN_LOW  = 2'b10
	} gen_state_t;

	// Settings that steer the internal gate generator
	typedef struct packed {
		logic       enable;
		logic       use_slow;
		logic [1:0] clk_sel;
		logic [3:0] high_code;
		logic [3:0] low_code;
	} gen_cfg_t;

	// Synchronised input levels
	typedef struct packed {
		logic pulse;
		logic gate_pin;
		logic aux;
		logic slow;
	} sync_in_t;

endpackage : freq_meter_pkg

// ==== src/window_gate_gen.sv ====
`timescale 1ns/1ps
`default_nettype none

module window_gate_gen (
	// Clock and reset
	input  wire logic                      clk_i,
	input  wire logic                      rst_i,
	// Settings and slow clock level (already synchronised)
	input  wire freq_meter_pkg::gen_cfg_t  cfg_i,
	input  wire logic                      slow_lvl_i,
	// Gate level
	output logic                           gate_o
);

	logic [freq_meter_pkg::DIV_W-1:0] fast_div_r;
	logic [freq_meter_pkg::DIV_W-1:0] slow_div_r;
	logic                             slow_prev_r;
	logic [4:0]                       left_r;
	freq_meter_pkg::gen_state_t       state_r;
	logic                             slow_rise;
	logic                             fast_hit;
	logic                             slow_hit;
	logic                             tick;

	// True when the low n bits of the divider are all ones
	function automatic logic stage_done(input logic [freq_meter_pkg::DIV_W-1:0] div,
	                                    input int n);
		logic [freq_meter_pkg::DIV_W-1:0] mask;
		mask = freq_meter_pkg::DIV_W'((1 << n) - 1);
		return &(div | ~mask);
	endfunction : stage_done

	// Free-running dividers: never reset by a counter clear
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			fast_div_r <= '0;
		end else begin
			fast_div_r <= fast_div_r + 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			slow_prev_r <= 1'b0;
			slow_div_r  <= '0;
		end else begin
			slow_prev_r <= slow_lvl_i;
			if (slow_rise) begin
				slow_div_r <= slow_div_r + 1'b1;
			end
		end
	end

	assign slow_rise = slow_lvl_i & ~slow_prev_r;
	assign fast_hit  = stage_done(fast_div_r, freq_meter_pkg::FAST_SHIFT0 + int'(cfg_i.clk_sel));
	assign slow_hit  = slow_rise
	                 & stage_done(slow_div_r, freq_meter_pkg::SLOW_SHIFT0 + int'(cfg_i.clk_sel));
	assign tick      = cfg_i.use_slow ? slow_hit : fast_hit;

	// High then low, repeating; codes sampled at each period start
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_r <= freq_meter_pkg::GEN_IDLE;
			left_r  <= '0;
		end else if (!cfg_i.enable) begin
			state_r <= freq_meter_pkg::GEN_IDLE;
			left_r  <= '0;
		end else begin
			case (state_r)
				freq_meter_pkg::GEN_IDLE: begin
					state_r <= freq_meter_pkg::GEN_WAIT;
				end
				freq_meter_pkg::GEN_WAIT: begin
					if (tick) begin
						state_r <= freq_meter_pkg::GEN_HIGH;
						left_r  <= freq_meter_pkg::PERIOD_BASE - {1'b0, cfg_i.high_code};
					end
				end
				freq_meter_pkg::GEN_HIGH: begin
					if (tick) begin
						if (left_r == 5'h01) begin
							state_r <= freq_meter_pkg::GEN_LOW;
							left_r  <= freq_meter_pkg::PERIOD_BASE
							         - {1'b0, cfg_i.low_code};
						end else begin
							left_r <= left_r - 5'h01;
						end
					end
				end
				freq_meter_pkg::GEN_LOW: begin
					if (tick) begin
						if (left_r == 5'h01) begin
							state_r <= freq_meter_pkg::GEN_HIGH;
							left_r  <= freq_meter_pkg::PERIOD_BASE
							         - {1'b0, cfg_i.high_code};
						end else begin
							left_r <= left_r - 5'h01;
						end
					end
				end
				default: begin
					state_r <= freq_meter_pkg::GEN_IDLE;
				end
			endcase
		end
	end

	assign gate_o = (state_r == freq_meter_pkg::GEN_HIGH);

endmodule : window_gate_gen

`default_nettype wire

// ==== dv/freq_meter_chk.sv ====
`timescale 1ns/1ps
`default_nettype none

module freq_meter_chk (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        cyc_i,
	input wire logic        stb_i,
	input wire logic [31:0] dat_o,
	input wire logic        ack_o,
	input wire logic        aux_timer_output_i,
	input wire logic        shared_port_pin_o,
	input wire logic        shared_port_pin_oe_n_o,
	input wire logic        measure_interrupt_o,
	input wire logic        gate_active_o
);
	logic gate_d_r;
	logic gate_dd_r;

	always_ff @(posedge clk_i) begin
		gate_d_r  <= rst_i ? 1'b0 : gate_active_o;
		gate_dd_r <= rst_i ? 1'b0 : gate_d_r;
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence req_s;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence ack_s;
		ack_o ##1 !ack_o;
	endsequence

	ack_resp_a: assert property (req_s |=> ack_s)
		else $error("bus answer missing or too long");
	ack_cause_a: assert property (ack_o |-> $past(cyc_i) && $past(stb_i))
		else $error("bus answer without request");
	dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0)
		else $error("read data outside answer");
	pin_off_a: assert property (shared_port_pin_oe_n_o |-> !shared_port_pin_o)
		else $error("pin driven while disabled");
	pin_follow_a: assert property (!shared_port_pin_oe_n_o && !$past(shared_port_pin_oe_n_o) |->
		shared_port_pin_o == $past(aux_timer_output_i))
		else $error("pin does not follow aux output");
	irq_pulse_a: assert property (measure_interrupt_o |=> !measure_interrupt_o)
		else $error("interrupt longer than one cycle");
	irq_fall_a: assert property ($fell(gate_active_o) |-> ##[0:1] measure_interrupt_o)
		else $error("no interrupt on gate fall");
	irq_cause_a: assert property (measure_interrupt_o |->
		(gate_active_o != gate_d_r) || (gate_d_r != gate_dd_r))
		else $error("interrupt without gate edge");
endmodule : freq_meter_chk

bind gated_frequency_counter freq_meter_chk u_chk (
	.clk_i                  (clk_i),
	.rst_i                  (rst_i),
	.cyc_i                  (cyc_i),
	.stb_i                  (stb_i),
	.dat_o                  (dat_o),
	.ack_o                  (ack_o),
	.aux_timer_output_i     (aux_timer_output_i),
	.shared_port_pin_o      (shared_port_pin_o),
	.shared_port_pin_oe_n_o (shared_port_pin_oe_n_o),
	.measure_interrupt_o    (measure_interrupt_o),
	.gate_active_o          (gate_active_o)
);

`default_nettype wire

// ==== dv/pulse_source_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module pulse_source_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Burst command
	input  wire logic       go_i,
	input  wire logic [4:0] count_i,
	input  wire logic       hold_i,
	// Pulse line
	output logic            pulse_o,
	output logic            busy_o
);
	logic [4:0] left_r;
	logic [2:0] ph_r;

	// Whole pulses, four cycles per level
	always_ff @(posedge clk_i) begin
		if (rst_i || go_i) begin
			left_r <= rst_i ? 5'h00 : count_i;
			ph_r   <= 3'h0;
		end else if (left_r != 5'h00) begin
			ph_r <= ph_r + 3'h1;
			if (ph_r == 3'h7) begin
				left_r <= left_r - 5'h01;
			end
		end
	end
	assign busy_o  = (left_r != 5'h00);
	assign pulse_o = hold_i | (busy_o & ph_r[2]);
endmodule : pulse_source_model

`default_nettype wire

// ==== dv/gated_frequency_counter_test.sv ====
`timescale 1ns/1ps
`default_nettype none

module gated_frequency_counter_test;
	logic        clk_i;
	logic        rst_i;
	logic        cyc_i;
	logic        stb_i;
	logic        we_i;
	logic [7:0]  adr_i;
	logic [3:0]  sel_i;
	logic [31:0] dat_i;
	logic [31:0] dat_o;
	logic        ack_o;
	logic        pulse;
	logic        gate_pin;
	logic        aux;
	logic        pin;
	logic        pin_oe_n;
	logic        irq;
	logic        gate_act;
	logic        go;
	logic [4:0]  npulse;
	logic        hold;
	logic        busy;
	logic [31:0] rd;
	logic [2:0]  slow_cnt;
	int          errors;
	int          checks;
	int          irqs;
	int          hi;
	int          lo;

	gated_frequency_counter #(.COUNT_W(4)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
		.measured_pulse_input_i(pulse), .gate_input_pin_i(gate_pin),
		.aux_timer_output_i(aux), .slow_clock_i(slow_cnt[2]), .shared_port_pin_o(pin),
		.shared_port_pin_oe_n_o(pin_oe_n), .measure_interrupt_o(irq), .gate_active_o(gate_act)
	);
	pulse_source_model src (
		.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .count_i(npulse),
		.hold_i(hold), .pulse_o(pulse), .busy_o(busy)
	);

	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Slow clock: one rising edge every eight cycles
	always @(posedge clk_i) begin
		slow_cnt <= rst_i ? 3'h0 : slow_cnt + 3'h1;
	end
	always @(posedge clk_i) begin
		if (irq === 1'b1) begin
			irqs++;
		end
	end

	task automatic final_report();
		if (errors == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : final_report

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i  <= w;
		adr_i <= a;
		dat_i <= d;
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
		end while (ack_o !== 1'b1 && i < 50);
		rd = dat_o;
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i  <= 1'b0;
		@(posedge clk_i);
		if (i >= 50) begin
			errors++;
			final_report();
		end
	endtask : bus

	task automatic wait_gate(input logic lvl, output int len);
		int i;
		i = 0;
		len = 0;
		while (gate_act !== lvl && i < 40000) begin
			@(posedge clk_i);
			i++;
		end
		while (gate_act === lvl && len < 40000) begin
			@(posedge clk_i);
			len++;
		end
		if (i >= 40000 || len >= 40000) begin
			errors++;
			final_report();
		end
	endtask : wait_gate

	// One pin-gated window with n pulses; hi keeps the pulse high across the gate fall
	task automatic window(input logic [4:0] n, input logic hi);
		int i;
		gate_pin <= 1'b1;
		repeat (6) @(posedge clk_i);
		npulse <= n;
		go     <= 1'b1;
		hold   <= hi;
		@(posedge clk_i);
		go <= 1'b0;
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("gate flag high", 32'h1, {31'h0, rd[0]});
		i = 0;
		while (busy === 1'b1 && i < 400) begin
			@(posedge clk_i);
			i++;
		end
		gate_pin <= 1'b0;
		repeat (8) @(posedge clk_i);
		hold <= 1'b0;
		repeat (8) @(posedge clk_i);
	endtask : window

	initial begin
		rst_i    = 1'b1;
		cyc_i    = 1'b0;
		stb_i    = 1'b0;
		we_i     = 1'b0;
		adr_i    = 8'h00;
		sel_i    = 4'hF;
		dat_i    = 32'h0;
		gate_pin = 1'b0;
		aux      = 1'b0;
		go       = 1'b0;
		npulse   = 5'h00;
		hold     = 1'b0;
		errors   = 0;
		checks   = 0;
		irqs     = 0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b1, 8'h14, 32'hFFFF_FFFF);
		for (int a = 0; a <= 8'h14; a += 4) begin
			bus(1'b0, a[7:0], 32'h0);
			check("reset or unmapped read", 32'h0, rd);
		end
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h003);
		irqs = 0;
		window(5'h05, 1'b0);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("count one window", 32'h5, rd);
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("status gate low", 32'h0, rd);
		check("irq on fall", 32'h1, irqs);
		window(5'h03, 1'b0);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("count resumes", 32'h8, rd);
		window(5'h00, 1'b1);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("gate fall on high input", 32'h9, rd);
		bus(1'b1, freq_meter_pkg::CLEAR_OFS, 32'h1);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("count cleared", 32'h0, rd);
		window(5'h11, 1'b0);
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("overflow set", 32'h2, rd);
		window(5'h00, 1'b0);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("count after wrap", 32'h1, rd);
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("overflow sticks", 32'h2, rd);
		bus(1'b1, freq_meter_pkg::CLEAR_OFS, 32'h1);
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("overflow cleared", 32'h0, rd);
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h023);
		window(5'h00, 1'b0);
		bus(1'b0, freq_meter_pkg::COUNT_OFS, 32'h0);
		check("both edge constant input", 32'h1, rd);
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h013);
		irqs = 0;
		window(5'h00, 1'b0);
		check("irq both edges", 32'h2, irqs);
		// Aux output as gate, routed then unrouted
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h00B);
		aux <= 1'b1;
		repeat (8) @(posedge clk_i);
		check("pin routed", 32'h2, {30'h0, pin, pin_oe_n});
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h20B);
		bus(1'b0, freq_meter_pkg::STATUS_OFS, 32'h0);
		check("aux gate kept", 32'h1, {31'h0, rd[0]});
		check("pin released", 32'h1, {30'h0, pin, pin_oe_n});
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h00F);
		gate_pin <= 1'b1;
		repeat (8) @(posedge clk_i);
		check("reserved gate low", 32'h0, {31'h0, gate_act});
		gate_pin <= 1'b0;
		aux      <= 1'b0;
		bus(1'b1, freq_meter_pkg::PERIOD_OFS, 32'hEF);
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h007);
		wait_gate(1'b1, hi);
		wait_gate(1'b0, lo);
		wait_gate(1'b1, hi);
		check("internal high span", 32'h1000, hi);
		check("internal low span", 32'h2000, lo);
		// Slow source during the low period: 16 slow edges per tick
		bus(1'b1, freq_meter_pkg::CTRL_OFS, 32'h107);
		wait_gate(1'b1, hi);
		wait_gate(1'b0, lo);
		check("slow high span", 32'h80, hi);
		check("slow low span", 32'h100, lo);
		final_report();
	end
endmodule : gated_frequency_counter_test

`default_nettype wire
